// ===== inc/fdl_pkg.sv
// Shared constants, types and the vector builder for the FDL interrupt vector block.
package fdl_pkg;
    localparam int VW = 16;
    localparam int AW = 6;
    localparam int QDEPTH = 8;
    localparam int QAW = 3;
    localparam logic [3:0] QFULL = 4'h8;
    localparam logic [1:0] TYPE_FDL = 2'h1;
    localparam logic [1:0] TYPE_DS3 = 2'h2;
    localparam logic [4:0] DS3_SOURCE_SELECT_FIELD = 5'h07;
    localparam logic [4:0] MAX_PORT = 5'h1b;
    localparam logic [4:0] POOL_LAST = 5'h1f;
    localparam logic [4:0] SPAN_LAST = 5'h1f;
    localparam logic [3:0] RUN_LEN = 4'h8;
    localparam logic [1:0] PERSIST_LAST = 2'h2;
    localparam logic [6:0] FIFO_DEPTH = 7'h40;
    localparam logic [6:0] POOL_FREE = 7'h20;
    localparam logic [5:0] A_CTRL = 6'h00;
    localparam logic [5:0] A_PSR = 6'h04;
    localparam logic [5:0] A_RSW1 = 6'h08;
    localparam logic [5:0] A_RSW2 = 6'h0c;
    localparam logic [5:0] A_RSW3 = 6'h10;
    localparam logic [5:0] A_RSYNC = 6'h14;
    localparam logic [5:0] A_TSW1 = 6'h18;
    localparam logic [5:0] A_TSW2 = 6'h1c;
    localparam logic [5:0] A_TSW3 = 6'h20;
    localparam logic [5:0] A_DS3STAT = 6'h24;
    localparam int CTRL_BOM = 0;
    localparam int CTRL_PORT_LSB = 8;
    localparam int REP_LSB = 8;
    localparam int RX_RSA = 4;
    localparam int RX_SSM = 3;
    localparam int RX_RPF = 2;
    localparam int RX_RME = 1;
    localparam int RX_ISF = 0;
    localparam int TX_SPARE_BITS_TX_DONE = 3;
    localparam int TX_TX_DRAINED = 2;
    localparam int TX_XDU = 1;
    localparam int TX_XPR = 0;
    localparam int LAST_BIT = 15;

    typedef enum logic [1:0] {
        FDL_SRC_NONE = 2'b00,
        FDL_SRC_RX = 2'b01,
        FDL_SRC_TX = 2'b10,
        FDL_SRC_DS3 = 2'b11
    } fdl_src_t;

    // Lays out one vector without its final flag; the queue adds that flag.
    function automatic logic [VW-1:0] fdl_make_vec(input fdl_src_t src, input logic [6:0] flags,
                                                   input logic [4:0] port);
        logic [VW-1:0] v;
        v = '0;
        case (src)
            FDL_SRC_RX: v = {1'b0, 3'h0, flags[4:0], TYPE_FDL, port};
            FDL_SRC_TX: v = {1'b0, 1'b1, 3'h0, flags[3:0], TYPE_FDL, port};
            FDL_SRC_DS3: v = {1'b0, 1'b0, flags, TYPE_DS3, DS3_SOURCE_SELECT_FIELD};
            default: v = '0;
        endcase
        return v;
    endfunction
endpackage

// ===== rtl/fdl_vec_queue.sv
// Ordered vector queue that marks the last vector of each delivered batch.
`timescale 1ns/100ps
module fdl_vec_queue (
    input wire logic mclk_i,
    input wire logic srst_i,
    input wire logic push_i,
    input wire logic [fdl_pkg::VW-1:0] push_data_i,
    output logic push_ready_o,
    output logic vec_valid_o,
    output logic [fdl_pkg::VW-1:0] vec_data_o,
    input wire logic vec_ready_i
);
    logic [fdl_pkg::VW-1:0] mem_r [fdl_pkg::QDEPTH];
    logic [fdl_pkg::QAW-1:0] wp_r;
    logic [fdl_pkg::QAW-1:0] rp_r;
    logic [fdl_pkg::QAW:0] cnt_r;
    logic out_valid_r;
    logic [fdl_pkg::VW-1:0] out_data_r;
    logic do_push;
    logic do_load;
    logic is_last;

    assign push_ready_o = cnt_r != fdl_pkg::QFULL;
    assign do_push = push_i && push_ready_o;
    assign do_load = (cnt_r != '0) && (!out_valid_r || vec_ready_i);
    assign is_last = (cnt_r == 4'h1) && !do_push;
    assign vec_valid_o = out_valid_r;
    assign vec_data_o = out_data_r;

    always_ff @(posedge mclk_i) begin
        if (do_push) begin
            mem_r[wp_r] <= push_data_i;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            if (do_push) begin
                wp_r <= wp_r + 1'b1;
            end
            if (do_load) begin
                rp_r <= rp_r + 1'b1;
            end
            case ({do_push, do_load})
                2'b10: cnt_r <= cnt_r + 1'b1;
                2'b01: cnt_r <= cnt_r - 1'b1;
                default: cnt_r <= cnt_r;
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            out_valid_r <= 1'b0;
            out_data_r <= '0;
        end else if (do_load) begin
            out_valid_r <= 1'b1;
            out_data_r <= {is_last, mem_r[rp_r][fdl_pkg::VW-2:0]};
        end else if (vec_ready_i) begin
            out_valid_r <= 1'b0;
        end
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (srst_i);
    property p_q_hold;
        vec_valid_o && !vec_ready_i |=> vec_valid_o && $stable(vec_data_o);
    endproperty
    a_q_hold: assert property (p_q_hold) else $error("vector changed while stalled");
    property p_q_last;
        do_load && (cnt_r > 4'h1) |=> !vec_data_o[fdl_pkg::LAST_BIT];
    endproperty
    a_q_last: assert property (p_q_last) else $error("final flag set with vectors still queued");
endmodule

// ===== rtl/fdl_vector_gen.sv
// Per-port facility data link and DS3 type-2 interrupt vector generator.
`timescale 1ns/100ps
module fdl_vector_gen (
    input wire logic mclk_i,
    input wire logic srst_i,
    input wire logic [fdl_pkg::AW-1:0] reg_addr_i,
    input wire logic [fdl_pkg::VW-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [fdl_pkg::VW-1:0] reg_rdata_o,
    input wire logic rx_spare_valid_i,
    input wire logic [7:0] rx_spare_w1_i,
    input wire logic [7:0] rx_spare_w2_i,
    input wire logic [7:0] rx_spare_w3_i,
    input wire logic sync_status_msg_valid_i,
    input wire logic [7:0] sync_status_msg_i,
    input wire logic rx_byte_stored_i,
    input wire logic rx_frame_end_i,
    input wire logic rx_fifo_pop_i,
    input wire logic bom_bit_en_i,
    input wire logic bom_bit_i,
    input wire logic spare_rep_sent_i,
    input wire logic tx_last_bit_i,
    input wire logic tx_fifo_empty_i,
    input wire logic tx_in_frame_i,
    input wire logic [6:0] tx_fifo_free_i,
    output logic tx_abort_o,
    output logic [7:0] tx_spare_w1_o,
    output logic [7:0] tx_spare_w2_o,
    output logic [7:0] tx_spare_w3_o,
    input wire logic [4:0] ds3_cond_i,
    input wire logic ds3_mf_i,
    input wire logic ds3_app_id_i,
    input wire logic ds3_x_overhead_chg_i,
    output logic vec_valid_o,
    output logic [fdl_pkg::VW-1:0] vec_data_o,
    input wire logic vec_ready_i
);
    logic bom_en_r;
    logic [4:0] port_r;
    logic [7:0] rx_spare_w1_r;
    logic [7:0] rx_spare_w2_r;
    logic [7:0] rx_spare_w3_r;
    logic [7:0] rx_sync_msg_r;
    logic [7:0] tx_spare_w1_r;
    logic [7:0] tx_spare_w2_r;
    logic [7:0] tx_spare_w3_r;
    logic [3:0] spare_repeat_count_r;
    logic [3:0] rep_cnt_r;
    logic [6:0] rx_fifo_cnt_r;
    logic [4:0] rx_part_cnt_r;
    logic [4:0] bom_span_r;
    logic [3:0] bom_ones_r;
    logic [4:0] cond_q_r;
    logic underrun_q_r;
    logic pool_q_r;
    logic tx_abort_r;
    logic [1:0] ovh_in;
    logic [1:0] ovh_rep_r;
    logic [1:0] ovh_cnt_r [2];
    logic [1:0] ovh_ev;
    logic [4:0] rx_ev;
    logic [3:0] tx_ev;
    logic [6:0] ds3_ev;
    logic [4:0] rx_pend_r;
    logic [3:0] tx_pend_r;
    logic [6:0] ds3_pend_r;
    logic [fdl_pkg::VW-1:0] rdata_r;
    logic push_ready;
    logic underrun_now;
    logic pool_now;
    logic fifo_inc;
    logic fifo_dec;
    logic rep_hit;
    fdl_pkg::fdl_src_t src;
    logic [6:0] src_flags;

    function automatic logic wr_at(input logic [fdl_pkg::AW-1:0] a);
        return reg_wr_i && (reg_addr_i == a);
    endfunction

    // Control register: bit-oriented receiver enable and port number.
    // port range check
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            bom_en_r <= 1'b0;
            port_r <= '0;
        end else if (wr_at(fdl_pkg::A_CTRL)) begin
            bom_en_r <= reg_wdata_i[fdl_pkg::CTRL_BOM];
            if (reg_wdata_i[fdl_pkg::CTRL_PORT_LSB +: 5] <= fdl_pkg::MAX_PORT) begin
                port_r <= reg_wdata_i[fdl_pkg::CTRL_PORT_LSB +: 5];
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            tx_spare_w1_r <= '0;
            tx_spare_w2_r <= '0;
            tx_spare_w3_r <= '0;
            spare_repeat_count_r <= '0;
        end else begin
            if (wr_at(fdl_pkg::A_TSW1)) begin
                tx_spare_w1_r <= reg_wdata_i[7:0];
            end
            if (wr_at(fdl_pkg::A_TSW2)) begin
                tx_spare_w2_r <= reg_wdata_i[7:0];
            end
            if (wr_at(fdl_pkg::A_TSW3)) begin
                tx_spare_w3_r <= reg_wdata_i[7:0];
                spare_repeat_count_r <= reg_wdata_i[fdl_pkg::REP_LSB +: 4];
            end
        end
    end
    assign tx_spare_w1_o = tx_spare_w1_r;
    assign tx_spare_w2_o = tx_spare_w2_r;
    assign tx_spare_w3_o = tx_spare_w3_r;

    // A count of zero is taken as one repetition; a write restarts counting.
    assign rep_hit = spare_rep_sent_i && (rep_cnt_r + 4'h1 >= spare_repeat_count_r);
    always_ff @(posedge mclk_i) begin
        if (srst_i || wr_at(fdl_pkg::A_TSW3)) begin
            rep_cnt_r <= '0;
        end else if (rep_hit) begin
            rep_cnt_r <= '0;
        end else if (spare_rep_sent_i) begin
            rep_cnt_r <= rep_cnt_r + 4'h1;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            rx_spare_w1_r <= '0;
            rx_spare_w2_r <= '0;
            rx_spare_w3_r <= '0;
        end else if (rx_spare_valid_i) begin
            rx_spare_w1_r <= rx_spare_w1_i;
            rx_spare_w2_r <= rx_spare_w2_i;
            rx_spare_w3_r <= rx_spare_w3_i;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            rx_sync_msg_r <= '0;
        end else if (sync_status_msg_valid_i) begin
            rx_sync_msg_r <= sync_status_msg_i;
        end
    end

    assign fifo_inc = rx_byte_stored_i && (rx_fifo_cnt_r != fdl_pkg::FIFO_DEPTH);
    assign fifo_dec = rx_fifo_pop_i && (rx_fifo_cnt_r != '0);
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            rx_fifo_cnt_r <= '0;
        end else if (fifo_inc && !fifo_dec) begin
            rx_fifo_cnt_r <= rx_fifo_cnt_r + 7'h01;
        end else if (fifo_dec && !fifo_inc) begin
            rx_fifo_cnt_r <= rx_fifo_cnt_r - 7'h01;
        end
    end

    // pool full and message end counting
    always_ff @(posedge mclk_i) begin
        if (srst_i || rx_frame_end_i) begin
            rx_part_cnt_r <= '0;
        end else if (rx_byte_stored_i) begin
            rx_part_cnt_r <= (rx_part_cnt_r == fdl_pkg::POOL_LAST) ? 5'h00 : rx_part_cnt_r + 5'h01;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i || !bom_en_r) begin
            bom_ones_r <= '0;
            bom_span_r <= '0;
        end else if (bom_bit_en_i) begin
            bom_ones_r <= !bom_bit_i ? 4'h0 : (bom_ones_r == fdl_pkg::RUN_LEN) ? bom_ones_r : bom_ones_r + 4'h1;
            if (bom_bit_i && bom_ones_r + 4'h1 >= fdl_pkg::RUN_LEN) begin
                bom_span_r <= '0;
            end else if (bom_span_r == fdl_pkg::SPAN_LAST) begin
                bom_span_r <= '0;
            end else begin
                bom_span_r <= bom_span_r + 5'h01;
            end
        end
    end

    assign rx_ev[fdl_pkg::RX_RSA] = rx_spare_valid_i;
    assign rx_ev[fdl_pkg::RX_SSM] = sync_status_msg_valid_i;
    assign rx_ev[fdl_pkg::RX_RPF] = rx_byte_stored_i && !rx_frame_end_i && (rx_part_cnt_r == fdl_pkg::POOL_LAST);
    assign rx_ev[fdl_pkg::RX_RME] = rx_frame_end_i;
    assign rx_ev[fdl_pkg::RX_ISF] = bom_en_r && bom_bit_en_i && (bom_span_r == fdl_pkg::SPAN_LAST) &&
                                    !(bom_bit_i && bom_ones_r + 4'h1 >= fdl_pkg::RUN_LEN);

    // Edge detection on the transmit levels.
    assign underrun_now = tx_fifo_empty_i && tx_in_frame_i;
    assign pool_now = tx_fifo_free_i >= fdl_pkg::POOL_FREE;
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            underrun_q_r <= 1'b0;
            pool_q_r <= 1'b0;
            tx_abort_r <= 1'b0;
        end else begin
            underrun_q_r <= underrun_now;
            pool_q_r <= pool_now;
            tx_abort_r <= underrun_now && !underrun_q_r;
        end
    end
    assign tx_abort_o = tx_abort_r;

    assign tx_ev[fdl_pkg::TX_SPARE_BITS_TX_DONE] = rep_hit;
    assign tx_ev[fdl_pkg::TX_TX_DRAINED] = tx_last_bit_i && tx_fifo_empty_i;
    assign tx_ev[fdl_pkg::TX_XDU] = underrun_now && !underrun_q_r;
    assign tx_ev[fdl_pkg::TX_XPR] = pool_now && !pool_q_r;

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            cond_q_r <= '0;
        end else begin
            cond_q_r <= ds3_cond_i;
        end
    end

    assign ovh_in = {ds3_app_id_i, ds3_x_overhead_chg_i};
    generate
        for (genvar g = 0; g < 2; g++) begin : g_ovh
            always_ff @(posedge mclk_i) begin
                if (srst_i) begin
                    ovh_rep_r[g] <= 1'b0;
                    ovh_cnt_r[g] <= '0;
                end else if (ds3_mf_i) begin
                    if (ovh_in[g] == ovh_rep_r[g]) begin
                        ovh_cnt_r[g] <= '0;
                    end else if (ovh_cnt_r[g] == fdl_pkg::PERSIST_LAST) begin
                        ovh_cnt_r[g] <= '0;
                        ovh_rep_r[g] <= ovh_in[g];
                    end else begin
                        ovh_cnt_r[g] <= ovh_cnt_r[g] + 2'h1;
                    end
                end
            end
            assign ovh_ev[g] = ds3_mf_i && (ovh_in[g] != ovh_rep_r[g]) && (ovh_cnt_r[g] == fdl_pkg::PERSIST_LAST);
        end
    endgenerate
    assign ds3_ev = {ovh_ev, ds3_cond_i ^ cond_q_r};

    // source order: receive, then transmit, then DS3.
    always_comb begin
        src = fdl_pkg::FDL_SRC_NONE;
        src_flags = '0;
        if (push_ready) begin
            if (rx_pend_r != '0) begin
                src = fdl_pkg::FDL_SRC_RX;
                src_flags = {2'b00, rx_pend_r};
            end else if (tx_pend_r != '0) begin
                src = fdl_pkg::FDL_SRC_TX;
                src_flags = {3'b000, tx_pend_r};
            end else if (ds3_pend_r != '0) begin
                src = fdl_pkg::FDL_SRC_DS3;
                src_flags = ds3_pend_r;
            end
        end
    end

    // Pending flags: an event in the cycle its flag is sent stays pending.
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            rx_pend_r <= '0;
            tx_pend_r <= '0;
            ds3_pend_r <= '0;
        end else begin
            rx_pend_r <= (src == fdl_pkg::FDL_SRC_RX ? 5'h00 : rx_pend_r) | rx_ev;
            tx_pend_r <= (src == fdl_pkg::FDL_SRC_TX ? 4'h0 : tx_pend_r) | tx_ev;
            ds3_pend_r <= (src == fdl_pkg::FDL_SRC_DS3 ? 7'h00 : ds3_pend_r) | ds3_ev;
        end
    end

    fdl_vec_queue u_queue (
        .mclk_i(mclk_i),
        .srst_i(srst_i),
        .push_i(src != fdl_pkg::FDL_SRC_NONE),
        .push_data_i(fdl_pkg::fdl_make_vec(src, src_flags, port_r)),
        .push_ready_o(push_ready),
        .vec_valid_o(vec_valid_o),
        .vec_data_o(vec_data_o),
        .vec_ready_i(vec_ready_i)
    );

    // Register read port: data stand only in the cycle after the strobe.
    always_ff @(posedge mclk_i) begin
        if (srst_i || !reg_rd_i) begin
            rdata_r <= '0;
        end else begin
            case (reg_addr_i)
                fdl_pkg::A_CTRL: rdata_r <= {3'h0, port_r, 7'h00, bom_en_r};
                fdl_pkg::A_PSR: rdata_r <= {9'h000, rx_fifo_cnt_r};
                fdl_pkg::A_RSW1: rdata_r <= {8'h00, rx_spare_w1_r};
                fdl_pkg::A_RSW2: rdata_r <= {8'h00, rx_spare_w2_r};
                fdl_pkg::A_RSW3: rdata_r <= {8'h00, rx_spare_w3_r};
                fdl_pkg::A_RSYNC: rdata_r <= {8'h00, rx_sync_msg_r};
                fdl_pkg::A_TSW1: rdata_r <= {8'h00, tx_spare_w1_r};
                fdl_pkg::A_TSW2: rdata_r <= {8'h00, tx_spare_w2_r};
                fdl_pkg::A_TSW3: rdata_r <= {4'h0, spare_repeat_count_r, tx_spare_w3_r};
                fdl_pkg::A_DS3STAT: rdata_r <= {9'h000, ovh_rep_r, cond_q_r};
                default: rdata_r <= '0;
            endcase
        end
    end
    assign reg_rdata_o = rdata_r;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (srst_i);
    property p_rsa;
        rx_spare_valid_i |=> rx_pend_r[fdl_pkg::RX_RSA] && (rx_spare_w3_r == $past(rx_spare_w3_i));
    endproperty
    a_rsa: assert property (p_rsa) else $error("spare data flag or word missing");
    property p_ssm;
        sync_status_msg_valid_i |=> rx_pend_r[fdl_pkg::RX_SSM] && (rx_sync_msg_r == $past(sync_status_msg_i));
    endproperty
    a_ssm: assert property (p_ssm) else $error("sync message not flagged or stored");
    property p_rpf;
        rx_byte_stored_i && !rx_frame_end_i && (rx_part_cnt_r == fdl_pkg::POOL_LAST) |=>
            rx_pend_r[fdl_pkg::RX_RPF] && (rx_part_cnt_r == '0);
    endproperty
    a_rpf: assert property (p_rpf) else $error("pool full missed at 32 bytes");
    property p_rme;
        rx_frame_end_i |=> rx_pend_r[fdl_pkg::RX_RME] && (rx_part_cnt_r == 5'h00);
    endproperty
    a_rme: assert property (p_rme) else $error("message end not flagged");
    property p_psr;
        reg_rd_i && (reg_addr_i == fdl_pkg::A_PSR) |=> reg_rdata_o[6:0] == $past(rx_fifo_cnt_r);
    endproperty
    a_psr: assert property (p_psr) else $error("status read does not show FIFO count");
    property p_isf;
        $rose(rx_pend_r[fdl_pkg::RX_ISF]) |-> $past(bom_en_r) && $past(bom_span_r) == fdl_pkg::SPAN_LAST;
    endproperty
    a_isf: assert property (p_isf) else $error("bad sync flagged outside a full span");
    property p_port;
        vec_valid_o && (vec_data_o[6:5] == 2'b01) |-> vec_data_o[4:0] <= fdl_pkg::MAX_PORT;
    endproperty
    a_port: assert property (p_port) else $error("port field out of range");
    property p_fdl_fmt;
        vec_valid_o && (vec_data_o[6:5] == 2'b01) |->
            (vec_data_o[14] ? vec_data_o[13:11] == 3'h0 : vec_data_o[14:12] == 3'h0);
    endproperty
    a_fdl_fmt: assert property (p_fdl_fmt) else $error("data link vector has stray bits");
    property p_xdu;
        underrun_now && !underrun_q_r |=> tx_abort_o && tx_pend_r[fdl_pkg::TX_XDU];
    endproperty
    a_xdu: assert property (p_xdu) else $error("underrun without abort or flag");
    property p_ds3_fmt;
        vec_valid_o && (vec_data_o[6:5] == 2'b10) |-> (vec_data_o[4:0] == 5'h07) && !vec_data_o[14];
    endproperty
    a_ds3_fmt: assert property (p_ds3_fmt) else $error("DS3 vector badly formed");
    property p_ovh;
        $changed(ovh_rep_r) |-> $past(ds3_mf_i) && $past(ovh_cnt_r[0] == 2'h2 || ovh_cnt_r[1] == 2'h2);
    endproperty
    a_ovh: assert property (p_ovh) else $error("overhead change reported too early");
    property p_ds3_chg;
        ds3_cond_i != cond_q_r |=> (ds3_pend_r[4:0] & $past(ds3_cond_i ^ cond_q_r)) == $past(ds3_cond_i ^ cond_q_r);
    endproperty
    a_ds3_chg: assert property (p_ds3_chg) else $error("DS3 change not flagged");
    c_rx: cover property (vec_valid_o && vec_ready_i && vec_data_o[6:5] == 2'b01 && !vec_data_o[14]);
    c_tx: cover property (vec_valid_o && vec_ready_i && vec_data_o[14] && vec_data_o[6:5] == 2'b01);
    c_ds3: cover property (vec_valid_o && vec_ready_i && vec_data_o[6:5] == 2'b10 && vec_data_o[15]);
endmodule

// ===== test/fdl_host_model.sv
// Host model that takes queued interrupt vectors, promptly or with stalls.
`timescale 1ns/100ps
module fdl_host_model (
    input wire logic mclk_i,
    input wire logic srst_i,
    input wire logic slow_i,
    input wire logic vec_valid_i,
    input wire logic [15:0] vec_data_i,
    output logic vec_ready_o
);
    logic [15:0] got[$];
    logic [1:0] stall_r;
    always @(posedge mclk_i) begin
        stall_r <= srst_i ? 2'h0 : stall_r + 2'h1;
        if (!srst_i && vec_valid_i && vec_ready_o) begin
            got.push_back(vec_data_i);
        end
    end
    assign vec_ready_o = !srst_i && (!slow_i || stall_r == 2'h3);
endmodule

// ===== test/tb_fdl_vector_gen.sv
// Self-checking bench for the FDL interrupt vector generator.
`timescale 1ns/100ps
module tb_fdl_vector_gen;
    logic mclk_i = 1'b0, srst_i = 1'b1, slow = 1'b0, wr = 1'b0, rd = 1'b0;
    logic tfe = 1'b0, tif = 1'b0, vv, rdy, abrt, bb = 1'b0, xb = 1'b0;
    logic [8:0] ev = 9'h000;
    logic [7:0] sb = 8'h00, tw1, tw2, tw3;
    logic [5:0] addr = 6'h00;
    logic [15:0] wd = 16'h0000, rdat, vd;
    logic [6:0] tfree = 7'h00;
    logic [4:0] cond = 5'h00, port = 5'h00;
    logic [31:0] seed = 32'h0000000d;
    int n_mismatch = 0, total_checks = 0, cyc = 0, cnt;
    always #10 mclk_i = ~mclk_i;
    fdl_vector_gen i_dut (.mclk_i(mclk_i), .srst_i(srst_i), .reg_addr_i(addr), .reg_wdata_i(wd),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat), .rx_spare_valid_i(ev[0]), .rx_spare_w1_i(sb),
        .rx_spare_w2_i(sb), .rx_spare_w3_i(sb), .sync_status_msg_valid_i(ev[1]), .sync_status_msg_i(sb),
        .rx_byte_stored_i(ev[2]), .rx_frame_end_i(ev[3]), .rx_fifo_pop_i(ev[4]), .bom_bit_en_i(ev[7]),
        .bom_bit_i(bb), .spare_rep_sent_i(ev[5]), .tx_last_bit_i(ev[6]), .tx_fifo_empty_i(tfe),
        .tx_in_frame_i(tif), .tx_fifo_free_i(tfree), .tx_abort_o(abrt), .tx_spare_w1_o(tw1), .tx_spare_w2_o(tw2),
        .tx_spare_w3_o(tw3), .ds3_cond_i(cond), .ds3_mf_i(ev[8]), .ds3_app_id_i(1'b0), .ds3_x_overhead_chg_i(xb),
        .vec_valid_o(vv), .vec_data_o(vd), .vec_ready_i(rdy));
    fdl_host_model i_host (.mclk_i(mclk_i), .srst_i(srst_i), .slow_i(slow), .vec_valid_i(vv),
        .vec_data_i(vd), .vec_ready_o(rdy));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function automatic logic [15:0] rxv(input logic [4:0] f);
        return {4'h8, f, 2'h1, port};
    endfunction
    function automatic logic [15:0] txv(input logic [3:0] f);
        return {4'hc, 1'b0, f, 2'h1, port};
    endfunction
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wreg(input logic [5:0] a, input logic [15:0] d);
        @(posedge mclk_i);
        addr <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge mclk_i);
        wr <= 1'b0;
    endtask
    task automatic rreg(input string nm, input logic [5:0] a, input logic [15:0] e);
        @(posedge mclk_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk_i);
        rd <= 1'b0;
        @(negedge mclk_i);
        chk(nm, e, rdat);
        @(posedge mclk_i);
    endtask
    // Each event input is pulsed for one cycle, with one idle cycle between pulses.
    task automatic pulse(input int k, input int n);
        repeat (n) begin
            @(posedge mclk_i);
            ev <= 9'h001 << k;
            @(posedge mclk_i);
            ev <= 9'h000;
        end
    endtask
    task automatic expv(input logic [15:0] e);
        int w;
        w = 0;
        while (i_host.got.size() == 0 && w < 40) begin
            @(posedge mclk_i);
            w++;
        end
        chk("vector", e, (w < 40) ? i_host.got.pop_front() : 16'hxxxx);
    endtask
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            end_of_test();
        end
    end
    initial begin
        repeat (3) @(posedge mclk_i);
        srst_i <= 1'b0;
        @(negedge mclk_i);
        chk("valid_after_reset", 16'h0000, {15'h0, vv});
        rreg("unmapped", 6'h3c, 16'h0000);
        for (int r = 0; r < 2; r++) begin
            seed = xs(seed);
            port = 5'(seed % 28);
            sb <= seed[15:8];
            slow <= r[0];
            wreg(6'h00, {3'h0, port, 8'h00});
            wreg(6'h00, 16'h1f00);
            rreg("port_kept", 6'h00, {3'h0, port, 8'h00});
            wreg(6'h00, {3'h0, port, 8'h01});
            bb <= 1'b1;
            pulse(7, 8);
            bb <= 1'b0;
            pulse(7, 31);
            repeat (6) @(posedge mclk_i);
            chk("early_bad_sync", 16'h0000, 16'(i_host.got.size()));
            pulse(7, 1);
            expv(rxv(5'h01));
            pulse(2, 5);
            pulse(3, 1);
            expv(rxv(5'h02));
            pulse(2, 32);
            expv(rxv(5'h04));
            rreg("fifo_count", 6'h04, 16'd37);
            pulse(4, 37);
            rreg("fifo_empty", 6'h04, 16'h0000);
            pulse(1, 1);
            expv(rxv(5'h08));
            rreg("sync_msg", 6'h14, {8'h00, sb});
            pulse(0, 1);
            expv(rxv(5'h10));
            rreg("rx_spare_w1", 6'h08, {8'h00, sb});
            tfree <= 7'h20;
            expv(txv(4'h1));
            tif <= 1'b1;
            tfe <= 1'b1;
            cnt = 0;
            repeat (6) @(negedge mclk_i) cnt += int'(abrt);
            chk("abort_pulses", 16'h0001, 16'(cnt));
            @(posedge mclk_i);
            expv(txv(4'h2));
            tif <= 1'b0;
            pulse(6, 1);
            expv(txv(4'h4));
            tfe <= 1'b0;
            tfree <= 7'h00;
            wreg(6'h18, {8'h00, sb});
            wreg(6'h1c, {8'h00, ~sb});
            wreg(6'h20, {8'h02, sb});
            @(negedge mclk_i);
            chk("tx_spare_w12", {sb, ~sb}, {tw1, tw2});
            chk("tx_spare_w3", {8'h00, sb}, {8'h00, tw3});
            rreg("rep_count", 6'h20, {8'h02, sb});
            pulse(5, 1);
            repeat (6) @(posedge mclk_i);
            chk("early_spare", 16'h0000, 16'(i_host.got.size()));
            pulse(5, 1);
            expv(txv(4'h8));
            @(posedge mclk_i);
            cond <= ~cond;
            expv({4'h8, 5'h1f, 2'h2, 5'h07});
            xb <= ~xb;
            pulse(8, 2);
            repeat (6) @(posedge mclk_i);
            chk("early_x_overhead_chg", 16'h0000, 16'(i_host.got.size()));
            pulse(8, 1);
            expv({4'h9, 5'h00, 2'h2, 5'h07});
            rreg("ds3_state", 6'h24, {10'h000, xb, cond});
        end
        end_of_test();
    end
endmodule
